// ===== rtl/adc_seq_pkg.sv
// Constants, register map and state type for the conversion sequencer.
// Assumes a single 100 MHz system clock and an AXI4-Lite register bus.
package adc_seq_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CLOCK_REF = 8'h04;
   localparam logic [7:0] OFS_RESULT = 8'h08;
   localparam logic [7:0] OFS_FUNC_SEL = 8'h0C;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTL_START_BIT = 7;
   localparam int CTL_BUSY_BIT = 6;
   localparam int CTL_POWER_BIT = 5;
   localparam int CTL_FORMAT_BIT = 4;
   localparam int CTL_CHAN_LSB = 0;
   localparam int CR_REF_HI_BIT = 4;
   localparam int CR_REF_LO_BIT = 3;
   localparam int CR_DIV_LSB = 0;
   localparam int CR_RANGE_BIT = 8;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic BUSY_RESET = 1'b1;
   localparam logic [3:0] CHAN_RESET = 4'h0;
   localparam logic [2:0] DIV_RESET = 3'h0;
   localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
   localparam logic [11:0] RESULT_RESET = 12'h000;

   // ------------------------------------------------------------
   // Conversion timing and codes
   // ------------------------------------------------------------
   localparam int SAMPLE_CLKS = 4;
   localparam int CONVERT_CLKS = 12;
   localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CLKS - 1);
   localparam logic [3:0] CONVERT_LAST = 4'(CONVERT_CLKS - 1);
   localparam logic [1:0] REF_EXT_CODE = 2'h1;
   localparam logic [3:0] CHAN_AMP0 = 4'h8;
   localparam logic [3:0] CHAN_AMP1 = 4'h9;
   localparam logic [3:0] CHAN_HV_DET = 4'hA;
   localparam logic [3:0] CHAN_OVERCUR = 4'hB;
   localparam logic [3:0] CHAN_BANDGAP = 4'hF;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_CLK_MIN_NS = 500;
   localparam int CONV_CLK_MAX_NS = 10000;

   // ------------------------------------------------------------
   // Bus responses and sequencer states
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ARMED = 2'h1,
      ST_SAMPLE = 2'h3,
      ST_CONVERT = 2'h2
   } seq_state_type;
endpackage

// ===== rtl/conv_clk_divider.sv
// Conversion clock divider: one tick every 2**div_sel system clocks.
// Assumes clear is driven from logic on the same clock.
`timescale 1ns/100ps
module conv_clk_divider #(
   parameter int SEL_W = 3
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic clear,
   input wire logic [SEL_W-1:0] div_sel,
   // Divided clock as a one-cycle enable
   output logic tick
);
   localparam int CNT_W = (1 << SEL_W) - 1;

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] mask;

   // ------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------
   generate
      if (SEL_W < 1 || SEL_W > 4) begin : g_bad_width
         $error("conv_clk_divider: SEL_W must lie in 1..4");
      end
   endgenerate

   // ------------------------------------------------------------
   // Free counter; clear realigns the first tick to a phase start
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   // Low div_sel bits of the counter all set marks the divided edge
   always_comb begin
      mask = CNT_W'((1 << div_sel) - 1);
      tick = ((count & mask) == mask);
   end
endmodule

// ===== rtl/adc_conversion_sequencer.sv
// Conversion sequencer for a 12-bit successive-approximation converter.
// Assumes the core, the analog mux and port logic run on aclk.
`timescale 1ns/100ps
module adc_conversion_sequencer
   import adc_seq_pkg::*;
#(
   parameter int RESULT_W = 12,
   parameter int PINS = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Converter core
   output logic core_power_up,
   output logic core_reset,
   output logic core_clk_tick,
   output logic core_sample,
   output logic core_convert,
   input wire logic [RESULT_W-1:0] core_result,
   // Reference and input multiplexer
   output logic ref_sel_ext,
   output logic [PINS-1:0] ext_input_sel,
   output logic [4:0] int_source_sel,
   output logic input_floating,
   // Interrupt controller request
   output logic conv_done,
   // Port pin control
   input wire logic [PINS-1:0] pin_pullup_req,
   input wire logic [PINS-1:0] pin_dir_out_req,
   output logic [PINS-1:0] pin_digital_en,
   output logic [PINS-1:0] pin_pullup_en,
   output logic [PINS-1:0] pin_output_en
);
   // ------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------
   generate
      if (RESULT_W != 12 || PINS != 8) begin : g_bad_param
         $error("adc_conversion_sequencer: only 12-bit result, 8 pins served");
      end
   endgenerate

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic aw_held, w_held, do_write;
   logic [7:0] wr_addr;
   logic [7:0] wr_byte;
   logic wr_lane;
   logic start, start_prev, start_rise, start_fall;
   logic power, format, ref_sel_hi, ref_sel_lo, busy;
   logic [3:0] input_channel_sel;
   logic [2:0] conv_clk_div_sel;
   logic [PINS-1:0] port_a_func_sel;
   logic [RESULT_W-1:0] result;
   logic [3:0] phase_cnt;
   logic tick, range_bad;
   logic [31:0] rd_value;
   logic rd_hit;
   seq_state_type state;

   // Divided conversion period outside the recommended window
   function automatic logic period_out_of_range(input logic [2:0] sel);
      int period_ns;
      period_ns = CLK_PERIOD_NS * (1 << sel);
      return (period_ns < CONV_CLK_MIN_NS) || (period_ns > CONV_CLK_MAX_NS);
   endfunction

   // ------------------------------------------------------------
   // AXI4-Lite write channel: address and data taken in any order
   // ------------------------------------------------------------
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= 8'h00;
         wr_byte <= 8'h00;
         wr_lane <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= {s_axi_awaddr[7:2], 2'h0};
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_byte <= s_axi_wdata[7:0];
            wr_lane <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Response once both halves are in; unmapped writes get SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         if (wr_addr == OFS_CONTROL || wr_addr == OFS_CLOCK_REF ||
             wr_addr == OFS_RESULT || wr_addr == OFS_FUNC_SEL) begin
            s_axi_bresp <= RESP_OKAY;
         end else begin
            s_axi_bresp <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Software registers; only byte lane 0 carries fields
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start <= 1'b0;
         power <= 1'b0;
         format <= 1'b0;
         input_channel_sel <= CHAN_RESET;
      end else if (do_write && wr_lane && wr_addr == OFS_CONTROL) begin
         start <= wr_byte[CTL_START_BIT];
         power <= wr_byte[CTL_POWER_BIT];
         format <= wr_byte[CTL_FORMAT_BIT];
         input_channel_sel <= wr_byte[CTL_CHAN_LSB +: 4];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_sel_hi <= 1'b0;
         ref_sel_lo <= 1'b0;
         conv_clk_div_sel <= DIV_RESET;
         port_a_func_sel <= FUNC_SEL_RESET;
      end else if (do_write && wr_lane) begin
         if (wr_addr == OFS_CLOCK_REF) begin
            ref_sel_hi <= wr_byte[CR_REF_HI_BIT];
            ref_sel_lo <= wr_byte[CR_REF_LO_BIT];
            conv_clk_div_sel <= wr_byte[CR_DIV_LSB +: 3];
         end
         if (wr_addr == OFS_FUNC_SEL) begin
            port_a_func_sel <= wr_byte;
         end
      end
   end

   // ------------------------------------------------------------
   // Start edge detection on the software bit
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_prev <= 1'b0;
      end else begin
         start_prev <= start;
      end
   end

   assign start_rise = start && !start_prev;
   assign start_fall = !start && start_prev;

   // ------------------------------------------------------------
   // Conversion clock divider, realigned while armed
   // ------------------------------------------------------------
   conv_clk_divider #(
      .SEL_W(3)
   ) u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(state == ST_ARMED),
      .div_sel(conv_clk_div_sel),
      .tick(tick)
   );

   // ------------------------------------------------------------
   // Sequencer: waits in ST_ARMED for start to fall; software only sees busy
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         busy <= BUSY_RESET;
         phase_cnt <= 4'h0;
         result <= RESULT_RESET;
         conv_done <= 1'b0;
         core_reset <= 1'b0;
      end else begin
         conv_done <= 1'b0;
         core_reset <= 1'b0;
         if (!power) begin
            state <= ST_IDLE;
         end else if (start_rise) begin
            // A new rising edge restarts even a conversion in flight
            state <= ST_ARMED;
            busy <= 1'b1;
            core_reset <= 1'b1;
         end else begin
            case (state)
               ST_ARMED: begin
                  if (start_fall) begin
                     state <= ST_SAMPLE;
                     phase_cnt <= 4'h0;
                  end
               end
               ST_SAMPLE: begin
                  if (tick) begin
                     if (phase_cnt == SAMPLE_LAST) begin
                        state <= ST_CONVERT;
                        phase_cnt <= 4'h0;
                     end else begin
                        phase_cnt <= phase_cnt + 4'h1;
                     end
                  end
               end
               ST_CONVERT: begin
                  if (tick) begin
                     if (phase_cnt == CONVERT_LAST) begin
                        state <= ST_IDLE;
                        busy <= 1'b0;
                        result <= core_result;
                        conv_done <= 1'b1;
                     end else begin
                        phase_cnt <= phase_cnt + 4'h1;
                     end
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Tick strobe and phase levels to the core
   assign core_clk_tick = tick && (state == ST_SAMPLE || state == ST_CONVERT);
   assign core_sample = (state == ST_SAMPLE);
   assign core_convert = (state == ST_CONVERT);

   // ------------------------------------------------------------
   // Analog routing, registered so the mux never sees a glitch
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_power_up <= 1'b0;
         ref_sel_ext <= 1'b0;
         ext_input_sel <= '0;
         int_source_sel <= 5'h00;
         input_floating <= 1'b0;
      end else begin
         core_power_up <= power;
         ref_sel_ext <= ({ref_sel_hi, ref_sel_lo} == REF_EXT_CODE);
         ext_input_sel <= '0;
         int_source_sel <= 5'h00;
         input_floating <= 1'b0;
         if (!input_channel_sel[3]) begin
            ext_input_sel[input_channel_sel[2:0]] <= 1'b1;
         end else begin
            case (input_channel_sel)
               CHAN_AMP0: int_source_sel[0] <= 1'b1;
               CHAN_AMP1: int_source_sel[1] <= 1'b1;
               CHAN_HV_DET: int_source_sel[2] <= 1'b1;
               CHAN_OVERCUR: int_source_sel[3] <= 1'b1;
               CHAN_BANDGAP: int_source_sel[4] <= 1'b1;
               default: input_floating <= 1'b1;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Pin ownership: analog selection wins over port settings
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_digital_en <= '1;
         pin_pullup_en <= '0;
         pin_output_en <= '0;
      end else begin
         pin_digital_en <= ~port_a_func_sel;
         pin_pullup_en <= pin_pullup_req & ~port_a_func_sel;
         pin_output_en <= pin_dir_out_req & ~port_a_func_sel;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel, one read at a time
   // ------------------------------------------------------------
   assign range_bad = period_out_of_range(conv_clk_div_sel);

   always_comb begin
      rd_value = 32'h0000_0000;
      rd_hit = 1'b1;
      case ({s_axi_araddr[7:2], 2'h0})
         OFS_CONTROL: rd_value[7:0] = {start, busy, power, format, input_channel_sel};
         OFS_CLOCK_REF: rd_value[8:0] = {range_bad, 3'h0, ref_sel_hi, ref_sel_lo,
                                         conv_clk_div_sel};
         // Format bit picks left or right justified result
         OFS_RESULT: rd_value[15:0] = format ? {4'h0, result} : {result, 4'h0};
         OFS_FUNC_SEL: rd_value[7:0] = port_a_func_sel;
         default: rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_value;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ===== testbench/core_mux_model.sv
// Far-side model: analog input mux and converter core.
// Assumes it shares aclk with the sequencer; the result encodes source and ticks.
`timescale 1ns/100ps
module core_mux_model (
   // Core control
   input wire logic aclk,
   input wire logic core_reset,
   input wire logic core_clk_tick,
   input wire logic core_sample,
   input wire logic core_convert,
   // Mux selection
   input wire logic [7:0] ext_input_sel,
   input wire logic [4:0] int_source_sel,
   input wire logic input_floating,
   // Result
   output logic [11:0] core_result
);
   logic [3:0] samp = 4'h0;
   logic [3:0] conv = 4'h0;
   logic [3:0] noise = 4'h0;
   logic [3:0] src;
   // Phase tick counts, cleared by each core reset
   always @(posedge aclk) begin
      noise <= noise + 4'h5;
      if (core_reset) begin
         samp <= 4'h0;
         conv <= 4'h0;
      end else begin
         samp <= samp + 4'(core_sample && core_clk_tick);
         conv <= conv + 4'(core_convert && core_clk_tick);
      end
   end
   // A floating input wanders every cycle, so no stale value can pass
   always_comb begin
      src = input_floating ? noise : ~noise;
      for (int i = 0; i < 8; i++)
         if (ext_input_sel[i])
            src = 4'(i);
      for (int i = 0; i < 4; i++)
         if (int_source_sel[i])
            src = 4'(8 + i);
      if (int_source_sel[4])
         src = 4'hF;
   end
   // Tick in flight included: the sampling edge sees 4 and 12
   assign core_result = {src, samp, conv + 4'(core_convert && core_clk_tick)};
endmodule

// ===== testbench/adc_conversion_sequencer_asserts.sv
// Checker for the conversion sequencer, bound to its top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module adc_seq_checker #(
   parameter int PINS = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Converter core
   input wire logic core_power_up,
   input wire logic core_reset,
   input wire logic core_clk_tick,
   input wire logic core_sample,
   input wire logic core_convert,
   input wire logic conv_done,
   // Pins
   input wire logic [PINS-1:0] pin_pullup_req,
   input wire logic [PINS-1:0] pin_dir_out_req,
   input wire logic [PINS-1:0] pin_digital_en,
   input wire logic [PINS-1:0] pin_pullup_en,
   input wire logic [PINS-1:0] pin_output_en
);
   logic [3:0] sp_cnt;
   logic [3:0] cv_cnt;
   // Ticks seen in the sample phase
   always_ff @(posedge aclk) begin
      if (!aresetn || !core_sample)
         sp_cnt <= 4'h0;
      else
         sp_cnt <= sp_cnt + 4'(core_clk_tick);
   end
   // Ticks seen in the convert phase; kept one cycle past it
   always_ff @(posedge aclk) begin
      if (!aresetn || !core_convert)
         cv_cnt <= 4'h0;
      else
         cv_cnt <= cv_cnt + 4'(core_clk_tick);
   end
   // ------------
   // Properties
   // ------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence last_tick_s;
      core_convert && core_clk_tick && cv_cnt == 4'hB;
   endsequence
   sequence sample_end_s;
      $fell(core_sample) && core_convert;
   endsequence
   sample_len_a: assert property (sample_end_s |-> sp_cnt == 4'h4)
      else $error("sample phase not four ticks");
   done_time_a: assert property (last_tick_s |=> conv_done && !core_convert)
      else $error("no completion after last tick");
   done_cause_a: assert property (conv_done |-> cv_cnt == 4'hC)
      else $error("completion without twelve ticks");
   done_pulse_a: assert property (conv_done |=> !conv_done)
      else $error("completion pulse too long");
   tick_gate_a: assert property (
      core_clk_tick |-> (core_sample || core_convert) && core_power_up)
      else $error("tick outside a conversion");
   power_gate_a: assert property (
      (core_sample || core_convert) |-> core_power_up || $past(core_power_up))
      else $error("conversion while powered down");
   reset_hold_a: assert property (
      core_reset |-> !core_sample && !core_convert ##1 !core_sample)
      else $error("sampling during start pulse");
   pullup_drop_a: assert property (
      $past(aresetn) |-> pin_pullup_en == ($past(pin_pullup_req) & pin_digital_en))
      else $error("pull-high kept on analog pin");
   dir_override_a: assert property (
      $past(aresetn) |-> pin_output_en == ($past(pin_dir_out_req) & pin_digital_en))
      else $error("drive kept on analog pin");
endmodule
bind adc_conversion_sequencer adc_seq_checker #(.PINS(PINS)) chk (.aclk, .aresetn,
   .core_power_up, .core_reset, .core_clk_tick, .core_sample, .core_convert, .conv_done,
   .pin_pullup_req, .pin_dir_out_req, .pin_digital_en, .pin_pullup_en, .pin_output_en);

// ===== testbench/adc_conversion_sequencer_bench.sv
// Self-checking bench for the conversion sequencer over AXI4-Lite.
// Assumes core_mux_model on the far side and a 100 MHz aclk.
`timescale 1ns/100ps
module adc_conversion_sequencer_bench
   import adc_seq_pkg::*;
;
   typedef struct packed {
      logic [3:0] chan;
      logic [2:0] div;
      logic [1:0] refc;
      logic [13:0] mux;
      logic eref;
   } row_type;
   // Channel, divider, reference in; {ext,int,float} and ref pin out
   row_type rows [16] = '{
      '{4'h0, 3'h0, 2'h0, 14'h0040, 1'h0}, '{4'h1, 3'h1, 2'h1, 14'h0080, 1'h1},
      '{4'h2, 3'h2, 2'h2, 14'h0100, 1'h0}, '{4'h3, 3'h3, 2'h3, 14'h0200, 1'h0},
      '{4'h4, 3'h4, 2'h0, 14'h0400, 1'h0}, '{4'h5, 3'h5, 2'h1, 14'h0800, 1'h1},
      '{4'h6, 3'h6, 2'h2, 14'h1000, 1'h0}, '{4'h7, 3'h7, 2'h3, 14'h2000, 1'h0},
      '{4'h8, 3'h0, 2'h0, 14'h0002, 1'h0}, '{4'h9, 3'h1, 2'h1, 14'h0004, 1'h1},
      '{4'hA, 3'h2, 2'h2, 14'h0008, 1'h0}, '{4'hB, 3'h3, 2'h3, 14'h0010, 1'h0},
      '{4'hC, 3'h4, 2'h0, 14'h0001, 1'h0}, '{4'hD, 3'h5, 2'h1, 14'h0001, 1'h1},
      '{4'hE, 3'h6, 2'h2, 14'h0001, 1'h0}, '{4'hF, 3'h7, 2'h3, 14'h0020, 1'h0}};
   logic aclk;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] pin_pullup_req = 8'hFF, pin_dir_out_req = 8'hAA;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, d;
   logic core_power_up, core_reset, core_clk_tick, core_sample, core_convert;
   logic [11:0] core_result;
   logic ref_sel_ext, input_floating, conv_done;
   logic [7:0] ext_input_sel, pin_digital_en, pin_pullup_en, pin_output_en;
   logic [4:0] int_source_sel;
   int fails = 0, checks_done = 0, cyc = 0, dones = 0, n, base;
   row_type r;

   adc_conversion_sequencer #(.RESULT_W(12), .PINS(8)) dut (.*);
   core_mux_model far (.*);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Ceiling about 3x the test length; counts completions
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (conv_done === 1'b1)
         dones <= dones + 1;
      if (cyc == 30000) begin
         fails++;
         report_and_stop();
      end
   end
   // -------------
   // Bus and checks
   // -------------
   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Idle edge first, so no strobe is set twice in one time step
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bit aw;
      bit w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      check_val(what, exp, d);
   endtask
   task automatic end_test(input string what);
      $display("test %s done", what);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // -------------
   // Main sequence
   // -------------
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk("control at reset", OFS_CONTROL, 32'h40);
      check_val("digital pins", 32'hFF, {24'h0, pin_digital_en});
      end_test("reset");
      wr(OFS_CONTROL, 32'h20);
      repeat (10) @(posedge aclk); // settling before any start
      foreach (rows[i]) begin
         r = rows[i];
         wr(OFS_CLOCK_REF, {27'h0, r.refc, r.div});
         rd_chk("clock ref", OFS_CLOCK_REF, {23'h0, r.div < 3'h6, 3'h0, r.refc, r.div});
         wr(OFS_CONTROL, {24'h0, 4'hA, r.chan});
         wr(OFS_CONTROL, {24'h0, 4'h2, r.chan});
         do @(posedge aclk); while (core_sample !== 1'b1);
         n = 1;
         while (conv_done !== 1'b1) begin
            @(posedge aclk);
            n++;
         end
         check_val("convert cycles", 32'(16 * (1 << r.div) + 1), 32'(n));
         check_val("mux lines", {18'h0, r.mux}, {18'h0, ext_input_sel, int_source_sel,
            input_floating});
         check_val("ref pin", {31'h0, r.eref}, {31'h0, ref_sel_ext});
         rd_chk("control done", OFS_CONTROL, {24'h0, 4'h2, r.chan});
         if (!r.mux[0])
            rd_chk("result", OFS_RESULT, {16'h0, r.chan, 8'h4C, 4'h0});
      end
      end_test("table");
      rd_chk("unmapped read", 8'h10, 32'h0);
      check_val("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      wr(8'h10, 32'hFF);
      check_val("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      wr(OFS_CLOCK_REF, 32'h0);
      base = dones;
      wr(OFS_CONTROL, 32'h80);
      wr(OFS_CONTROL, 32'h00);
      repeat (40) @(posedge aclk);
      check_val("done while off", base, dones);
      check_val("power while off", 32'h0, {31'h0, core_power_up});
      rd_chk("control while off", OFS_CONTROL, 32'h0);
      wr(OFS_CLOCK_REF, 32'h3);
      wr(OFS_CONTROL, 32'h30);
      repeat (10) @(posedge aclk); // settling
      wr(OFS_CONTROL, 32'hB3);
      rd_chk("busy on rise", OFS_CONTROL, 32'hF3);
      check_val("held off", 32'h0, {31'h0, core_sample});
      wr(OFS_CONTROL, 32'h33);
      do rd(OFS_CONTROL); while (d[6] !== 1'b0); // poll busy
      rd_chk("result right", OFS_RESULT, 32'h0000034C);
      check_val("done events", base + 1, dones);
      wr(OFS_CLOCK_REF, 32'h7);
      wr(OFS_CONTROL, 32'hA1);
      wr(OFS_CONTROL, 32'h21);
      repeat (100) @(posedge aclk);
      wr(OFS_CONTROL, 32'h01);
      repeat (20) @(posedge aclk);
      rd_chk("busy after abort", OFS_CONTROL, 32'h41);
      check_val("no done on abort", base + 1, dones);
      check_val("core off", 32'h0, {30'h0, core_power_up, core_convert});
      end_test("start and abort");
      wr(OFS_FUNC_SEL, 32'h0F);
      repeat (2) @(posedge aclk);
      check_val("pins", 32'hF0F0A0, {8'h0, pin_digital_en, pin_pullup_en,
         pin_output_en});
      wr(OFS_CONTROL, 32'h21);
      repeat (10) @(posedge aclk); // settling
      wr(OFS_CONTROL, 32'hA1);
      wr(OFS_CONTROL, 32'h21);
      repeat (50) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      check_val("sampling stopped", 32'h0, {31'h0, core_sample});
      rd_chk("control after reset", OFS_CONTROL, 32'h40);
      check_val("pins after reset", 32'hFF, {24'h0, pin_digital_en});
      end_test("pins and reset");
      report_and_stop();
   end
endmodule
